// >>> logic/analog_ramp_generator.sv
// module: analog ramp generator with start hold, decelerated stop and scaled output
//
// Contract
// RULE_01 - scaled output is (level minus offset) divided by gain, clamped to 0..32767.
// RULE_02 - a rising enable forces the level to start/stop level and holds it one tick.
// RULE_03 - after the start hold the level ramps toward the selected target at the rate.
// RULE_04 - a stop ramps to the start/stop level, holds one tick, then drops to the offset.
// RULE_05 - after a stop no restart occurs until both stop and enable have been low.
// RULE_06 - a select change ramps from the present level to the new target at the rate.
// RULE_07 - enable low sets the level to the offset at once, so the output is zero.
// RULE_08 - the level is recomputed once per 100 ms tick.
// RULE_09 - the display value is the unscaled current level.
// RULE_10 - each target may come from another block's actual value chosen by number.
// RULE_11 - select low picks target one, select high picks target two.
// RULE_12 - the level never exceeds the maximum level.
// RULE_13 - rate is steps per second, 1 to 10000.
// RULE_14 - start/stop level is start/stop offset (0..20000) plus the offset.
// RULE_15 - each tick moves one tenth of the rate toward the target with no overshoot; below a rate of 10 the code still moves 1 step per tick.
`timescale 1ns/1ps
`default_nettype none

module analog_ramp_generator #(
    parameter longint TICK_CYCLES = ramp_pkg::TICK_CYCLES,
    parameter int     NUM_BLOCKS  = 256
) (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        arst_n,
    // function inputs (pins)
    input  wire logic                        enable,
    input  wire logic                        level_sel,
    input  wire logic                        decel_stop,
    // actual values of other blocks, flattened by block number
    input  wire logic [NUM_BLOCKS*18-1:0]    block_values,
    // register port
    input  wire logic [3:0]                  reg_addr,
    input  wire logic [31:0]                 reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [31:0]                 reg_rdata,
    // outputs
    output logic      [15:0]                 scaled_out,
    output logic signed [17:0]               display_level
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [2:0] en_s_q;
    logic [2:0] sel_s_q;
    logic [2:0] stp_s_q;
    logic       en_f_q;
    logic       sel_f_q;
    logic       stp_f_q;

    // three stages, filtered on agreement of second and third
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            en_s_q  <= 3'h0;
            sel_s_q <= 3'h0;
            stp_s_q <= 3'h0;
        end
        else
        begin
            en_s_q  <= {en_s_q[1:0], enable};
            sel_s_q <= {sel_s_q[1:0], level_sel};
            stp_s_q <= {stp_s_q[1:0], decel_stop};
        end
    end

    // filtered levels
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            en_f_q  <= 1'b0;
            sel_f_q <= 1'b0;
            stp_f_q <= 1'b0;
        end
        else
        begin
            if (en_s_q[1] == en_s_q[2])
                en_f_q <= en_s_q[2];
            if (sel_s_q[1] == sel_s_q[2])
                sel_f_q <= sel_s_q[2];
            if (stp_s_q[1] == stp_s_q[2])
                stp_f_q <= stp_s_q[2];
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    ramp_pkg::ramp_cfg_t cfg_q;

    wire wr_ctrl = reg_wr && (reg_addr == ramp_pkg::REG_CTRL);
    wire wr_t1   = reg_wr && (reg_addr == ramp_pkg::REG_TARGET1);
    wire wr_t2   = reg_wr && (reg_addr == ramp_pkg::REG_TARGET2);
    wire wr_max  = reg_wr && (reg_addr == ramp_pkg::REG_MAXLVL);
    wire wr_sso  = reg_wr && (reg_addr == ramp_pkg::REG_SSO);
    wire wr_rate = reg_wr && (reg_addr == ramp_pkg::REG_RATE);
    wire wr_gain = reg_wr && (reg_addr == ramp_pkg::REG_GAIN);
    wire wr_off  = reg_wr && (reg_addr == ramp_pkg::REG_OFFSET);

    // clamp functions for written parameters
    function automatic logic [13:0] clamp_rate(input logic [31:0] v);
        logic [13:0] r;
        r = v[13:0];
        if (v[31:14] != 18'h00000 || r > ramp_pkg::RATE_MAX)
            r = ramp_pkg::RATE_MAX;
        else if (r < ramp_pkg::RATE_MIN)
            r = ramp_pkg::RATE_MIN;
        return r;
    endfunction

    function automatic logic [17:0] clamp_sso(input logic [31:0] v);
        logic [17:0] r;
        r = v[17:0];
        if (v[31:18] != 14'h0000 || r > ramp_pkg::SSO_MAX)
            r = ramp_pkg::SSO_MAX;
        return r;
    endfunction

    // parameter writes
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfg_q                   <= '0;
            cfg_q.target_one        <= ramp_pkg::RST_TARGET;
            cfg_q.target_two        <= ramp_pkg::RST_TARGET;
            cfg_q.max_level         <= ramp_pkg::RST_MAXLVL;
            cfg_q.rate              <= ramp_pkg::RST_RATE;
            cfg_q.gain              <= ramp_pkg::RST_GAIN;
        end
        else
        begin
            if (wr_ctrl)
            begin
                cfg_q.src1_ext <= reg_wdata[ramp_pkg::CTRL_SRC1];
                cfg_q.src2_ext <= reg_wdata[ramp_pkg::CTRL_SRC2];
                cfg_q.blk1     <= reg_wdata[ramp_pkg::CTRL_BLK1_LO +: 8];
                cfg_q.blk2     <= reg_wdata[ramp_pkg::CTRL_BLK2_LO +: 8];
            end
            if (wr_t1)
                cfg_q.target_one <= reg_wdata[17:0];
            if (wr_t2)
                cfg_q.target_two <= reg_wdata[17:0];
            if (wr_max)
                cfg_q.max_level <= reg_wdata[17:0];
            if (wr_sso)
                cfg_q.start_stop_offset <= clamp_sso(reg_wdata); // RULE_14
            if (wr_rate)
                cfg_q.rate <= clamp_rate(reg_wdata); // RULE_13
            if (wr_gain)
                cfg_q.gain <= reg_wdata[10:0];
            if (wr_off)
                cfg_q.offset <= reg_wdata[17:0];
        end
    end

    // ------------------------------------------------------------
    // target selection and levels
    // ------------------------------------------------------------
    function automatic logic signed [17:0] pick_block(input logic [7:0] n,
                                                      input logic [NUM_BLOCKS*18-1:0] v);
        logic signed [17:0] r;
        r = '0;
        if (32'(n) < NUM_BLOCKS)
            r = v[n*18 +: 18];
        return r;
    endfunction

    wire signed [17:0] t1_val = cfg_q.src1_ext ? pick_block(cfg_q.blk1, block_values)
                                               : cfg_q.target_one; // RULE_10
    wire signed [17:0] t2_val = cfg_q.src2_ext ? pick_block(cfg_q.blk2, block_values)
                                               : cfg_q.target_two; // RULE_10
    wire signed [17:0] sel_target = sel_f_q ? t2_val : t1_val; // RULE_11
    wire signed [17:0] ss_level   = cfg_q.offset + $signed(cfg_q.start_stop_offset); // RULE_14
    wire        [13:0] step_raw   = cfg_q.rate / ramp_pkg::TICKS_PER_S; // RULE_15
    wire signed [17:0] step       = (step_raw == 14'h0000) ? 18'sh00001 : $signed({4'h0, step_raw});

    // limit a level to the maximum level
    function automatic logic signed [17:0] cap(input logic signed [17:0] v,
                                               input logic signed [17:0] m);
        return (v > m) ? m : v;
    endfunction

    // one step toward a goal without overshoot
    function automatic logic signed [17:0] approach(input logic signed [17:0] cur,
                                                    input logic signed [17:0] goal,
                                                    input logic signed [17:0] s);
        logic signed [18:0] nxt;
        nxt = '0;
        if (cur < goal)
        begin
            nxt = 19'(cur) + 19'(s);
            return (nxt > 19'(goal)) ? goal : nxt[17:0];
        end
        else if (cur > goal)
        begin
            nxt = 19'(cur) - 19'(s);
            return (nxt < 19'(goal)) ? goal : nxt[17:0];
        end
        return cur;
    endfunction

    // ------------------------------------------------------------
    // sequence control
    // ------------------------------------------------------------
    ramp_pkg::ramp_state_t state_q;
    ramp_pkg::ramp_state_t state_d;
    logic signed [17:0]    level_q;
    logic signed [17:0]    level_d;
    logic                  en_prev_q;
    logic                  tick;

    wire en_rise = en_f_q && !en_prev_q;
    wire restart = en_rise && (state_q == ramp_pkg::ST_IDLE);

    tick_divider #(
        .PERIOD  (TICK_CYCLES)
    ) u_tick (
        .clk     (clk),
        .arst_n  (arst_n),
        .restart (restart),
        .tick    (tick)
    );

    // next state and level
    always_comb
    begin
        state_d = state_q;
        level_d = level_q;
        case (state_q)
            ramp_pkg::ST_IDLE:
            begin
                level_d = cfg_q.offset;
                if (en_rise && !stp_f_q)
                begin
                    state_d = ramp_pkg::ST_START_HOLD;
                    level_d = ss_level; // RULE_02
                end
            end
            ramp_pkg::ST_START_HOLD:
                if (tick)
                    state_d = ramp_pkg::ST_RUN; // RULE_02
            ramp_pkg::ST_RUN:
                if (stp_f_q)
                    state_d = ramp_pkg::ST_DECEL; // RULE_04
                else if (tick)
                    level_d = approach(level_q, sel_target, step); // RULE_03 RULE_06 RULE_08
            ramp_pkg::ST_DECEL:
                if (tick)
                begin
                    level_d = approach(level_q, ss_level, step); // RULE_04
                    if (level_d == ss_level)
                        state_d = ramp_pkg::ST_STOP_HOLD;
                end
            ramp_pkg::ST_STOP_HOLD:
                if (tick)
                begin
                    state_d = ramp_pkg::ST_LOCKED; // RULE_04
                    level_d = cfg_q.offset;
                end
            ramp_pkg::ST_LOCKED:
            begin
                level_d = cfg_q.offset;
                if (!stp_f_q && !en_f_q)
                    state_d = ramp_pkg::ST_IDLE; // RULE_05
            end
            default:
                state_d = ramp_pkg::ST_IDLE;
        endcase
        // enable low drops the level at once
        if (!en_f_q && state_q != ramp_pkg::ST_LOCKED)
        begin
            state_d = ramp_pkg::ST_IDLE; // RULE_07
            level_d = cfg_q.offset;
        end
        level_d = cap(level_d, cfg_q.max_level); // RULE_12
    end

    // state registers
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q   <= ramp_pkg::ST_IDLE;
            level_q   <= '0;
            en_prev_q <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            level_q   <= level_d;
            en_prev_q <= en_f_q;
        end
    end

    // ------------------------------------------------------------
    // scaled output
    // ------------------------------------------------------------
    // gain is in hundredths: out = (level - offset) * 100 / gain
    wire signed [19:0] diff   = 20'(level_q) - 20'(cfg_q.offset);
    wire signed [27:0] num    = 28'(diff) * 28'sd100;
    wire signed [27:0] quot   = (cfg_q.gain == 11'h000) ? 28'sh0000000
                                : num / $signed({17'h00000, cfg_q.gain});
    wire        [15:0] sc_d   = (quot < 28'sh0000000) ? 16'h0000
                                : (quot > 28'(ramp_pkg::OUT_MAX)) ? 16'h7fff
                                : quot[15:0]; // RULE_01

    // output flops
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            scaled_out    <= 16'h0000;
            display_level <= '0;
        end
        else
        begin
            scaled_out    <= sc_d; // RULE_01
            display_level <= level_q; // RULE_09
        end
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    logic [31:0] rd_d;

    // read decode
    always_comb
    begin
        if (reg_addr == ramp_pkg::REG_CTRL)
            rd_d = {8'h00, cfg_q.blk2, cfg_q.blk1, 6'h00, cfg_q.src2_ext, cfg_q.src1_ext};
        else if (reg_addr == ramp_pkg::REG_TARGET1)
            rd_d = {{14{cfg_q.target_one[17]}}, cfg_q.target_one};
        else if (reg_addr == ramp_pkg::REG_TARGET2)
            rd_d = {{14{cfg_q.target_two[17]}}, cfg_q.target_two};
        else if (reg_addr == ramp_pkg::REG_MAXLVL)
            rd_d = {{14{cfg_q.max_level[17]}}, cfg_q.max_level};
        else if (reg_addr == ramp_pkg::REG_SSO)
            rd_d = {14'h0000, cfg_q.start_stop_offset};
        else if (reg_addr == ramp_pkg::REG_RATE)
            rd_d = {18'h00000, cfg_q.rate};
        else if (reg_addr == ramp_pkg::REG_GAIN)
            rd_d = {21'h000000, cfg_q.gain};
        else if (reg_addr == ramp_pkg::REG_OFFSET)
            rd_d = {{14{cfg_q.offset[17]}}, cfg_q.offset};
        else if (reg_addr == ramp_pkg::REG_LEVEL)
            rd_d = {{14{level_q[17]}}, level_q}; // RULE_09
        else if (reg_addr == ramp_pkg::REG_STATUS)
            rd_d = {29'h00000000, state_q};
        else if (reg_addr == ramp_pkg::REG_SCALED)
            rd_d = {16'h0000, scaled_out};
        else
            rd_d = 32'h00000000;
    end

    // read data one cycle after strobe
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 32'h00000000;
        else if (reg_rd)
            reg_rdata <= rd_d;
        else
            reg_rdata <= 32'h00000000;
    end

endmodule

`default_nettype wire

// >>> logic/ramp_pkg.sv
// package: constants and carrier types for the analog ramp generator
package ramp_pkg;

    // ------------------------------------------------------------
    // widths and ranges
    // ------------------------------------------------------------
    localparam int                LEVEL_W    = 18;
    localparam int                OUT_W      = 16;
    localparam int                GAIN_W     = 11;
    localparam int                RATE_W     = 14;
    localparam int                BLOCK_W    = 8;
    localparam logic signed [17:0] OUT_MAX   = 18'sh07fff;
    localparam logic signed [17:0] OUT_MIN   = 18'sh00000;
    localparam logic [13:0]       RATE_MIN   = 14'h0001;
    localparam logic [13:0]       RATE_MAX   = 14'h2710;
    localparam logic [17:0]       SSO_MAX    = 18'h04e20;
    localparam logic [10:0]       GAIN_ONE   = 11'h064;
    localparam logic [13:0]       TICKS_PER_S = 14'h000a;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ        = 20000000;
    localparam longint TICK_MS       = 100;
    localparam longint TICK_CYCLES   = (CLK_HZ * TICK_MS) / 1000;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL      = 4'h0;
    localparam logic [3:0] REG_TARGET1   = 4'h1;
    localparam logic [3:0] REG_TARGET2   = 4'h2;
    localparam logic [3:0] REG_MAXLVL    = 4'h3;
    localparam logic [3:0] REG_SSO       = 4'h4;
    localparam logic [3:0] REG_RATE      = 4'h5;
    localparam logic [3:0] REG_GAIN      = 4'h6;
    localparam logic [3:0] REG_OFFSET    = 4'h7;
    localparam logic [3:0] REG_LEVEL     = 4'h8;
    localparam logic [3:0] REG_STATUS    = 4'h9;
    localparam logic [3:0] REG_SCALED    = 4'ha;

    // ctrl field positions
    localparam int CTRL_SRC1   = 0;
    localparam int CTRL_SRC2   = 1;
    localparam int CTRL_BLK1_LO = 8;
    localparam int CTRL_BLK2_LO = 16;

    // reset values
    localparam logic [17:0] RST_TARGET = 18'h00000;
    localparam logic [17:0] RST_MAXLVL = 18'h04e20;
    localparam logic [13:0] RST_RATE   = 14'h0001;
    localparam logic [10:0] RST_GAIN   = 11'h064;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START_HOLD,
        ST_RUN,
        ST_DECEL,
        ST_STOP_HOLD,
        ST_LOCKED
    } ramp_state_t;

    typedef struct packed {
        logic signed [17:0] target_one;
        logic signed [17:0] target_two;
        logic signed [17:0] max_level;
        logic        [17:0] start_stop_offset;
        logic        [13:0] rate;
        logic        [10:0] gain;
        logic signed [17:0] offset;
        logic               src1_ext;
        logic               src2_ext;
        logic        [7:0]  blk1;
        logic        [7:0]  blk2;
    } ramp_cfg_t;

endpackage

// >>> logic/tick_divider.sv
// module: periodic one-cycle tick enable from the system clock
`timescale 1ns/1ps
`default_nettype none

module tick_divider #(
    parameter longint PERIOD = ramp_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // restart the period
    input  wire logic restart,
    // one-cycle tick
    output logic      tick
);
    localparam int CW = $clog2(PERIOD);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    wire           at_last = (cnt_q == LAST);

    // next count wraps at the period end
    assign cnt_d = (restart || at_last) ? '0 : cnt_q + CW'(1);
    assign tick  = at_last && !restart;

    // counter
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

endmodule

`default_nettype wire

// >>> tb/ramp_monitor.sv
// checker: port-level properties of the analog ramp generator
`timescale 1ns/1ps
`default_nettype none

module ramp_monitor #(
    parameter longint TICK_CYCLES = 20
) (
    // clock and reset
    input wire logic                     clk,
    input wire logic                     arst_n,
    // function pins
    input wire logic                     enable,
    input wire logic                     decel_stop,
    // register port
    input wire logic [3:0]               reg_addr,
    input wire logic [31:0]              reg_wdata,
    input wire logic                     reg_wr,
    input wire logic                     reg_rd,
    input wire logic [31:0]              reg_rdata,
    // outputs
    input wire logic [15:0]              scaled_out,
    input wire logic signed [17:0]       display_level
);
    // --------
    // shadow state
    // --------
    logic signed [17:0] off_q;
    logic signed [17:0] max_q;
    logic        [17:0] sso_q;
    logic signed [18:0] step_q;
    int                 calm_q;
    int                 since_q;

    // settings follow register writes; step is rate/10, at least 1
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
        begin
            off_q  <= '0;
            max_q  <= 18'sh04e20;
            sso_q  <= '0;
            step_q <= 19'sh00001;
        end
        else if (reg_wr)
        begin
            if (reg_addr == ramp_pkg::REG_OFFSET) off_q <= reg_wdata[17:0];
            if (reg_addr == ramp_pkg::REG_MAXLVL) max_q <= reg_wdata[17:0];
            if (reg_addr == ramp_pkg::REG_SSO) sso_q <= reg_wdata[17:0];
            if (reg_addr == ramp_pkg::REG_RATE)
                step_q <= (reg_wdata[13:0] < 14'h0014) ? 19'sh00001 : 19'(reg_wdata[13:0] / 14'h000a);
        end

    // cycles since pins moved and since level moved
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
        begin
            calm_q  <= 0;
            since_q <= 0;
        end
        else
        begin
            calm_q  <= ($changed(enable) || $changed(decel_stop)) ? 0 : calm_q + (calm_q < 1000);
            since_q <= $changed(display_level) ? 0 : since_q + (since_q < 100000);
        end

    // --------
    // properties
    // --------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_scaled_range: assert property (
        scaled_out <= 16'h7fff) else $error("scaled output above range");
    a_scaled_zero: assert property (
        (display_level == off_q) [*3] |-> scaled_out == 16'h0) else $error("scaled not zero");
    a_read_level: assert property (
        $past(reg_rd) && $past(reg_addr) == ramp_pkg::REG_LEVEL |->
        reg_rdata[17:0] == display_level) else $error("level read wrong");
    a_level_cap: assert property (
        display_level <= max_q) else $error("level above maximum");
    a_start_level: assert property (
        $rose(enable) && !decel_stop |-> ##[2:10] display_level == off_q + sso_q)
        else $error("start level wrong");
    a_start_hold: assert property (
        $rose(enable) && !decel_stop |-> ##10 $stable(display_level) [*8])
        else $error("start level not held");
    a_step_size: assert property (
        enable && !decel_stop && calm_q >= 12 && $changed(display_level) |->
        display_level - $past(display_level) <= step_q && $past(display_level) - display_level <= step_q)
        else $error("step too large");
    a_tick_spacing: assert property (
        enable && !decel_stop && calm_q >= 12 && $changed(display_level) |->
        since_q >= TICK_CYCLES - 2) else $error("level moved between ticks");
    a_enable_off: assert property (
        $fell(enable) |-> ##[1:10] display_level == off_q && scaled_out == 16'h0)
        else $error("level not at offset");
endmodule

bind analog_ramp_generator ramp_monitor #(.TICK_CYCLES(TICK_CYCLES))
    ramp_monitor_inst (.clk(clk), .arst_n(arst_n), .enable(enable),
    .decel_stop(decel_stop), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .scaled_out(scaled_out), .display_level(display_level));
`default_nettype wire

// >>> tb/analog_ramp_generator_test.sv
// testbench: self-checking random and corner runs of the analog ramp generator
`timescale 1ns/1ps
`default_nettype none

module analog_ramp_generator_test;
    localparam longint T  = 20;
    localparam int     NB = 4;
    logic               clk, arst_n, enable, level_sel, decel_stop, reg_wr, reg_rd;
    logic [NB*18-1:0]   block_values;
    logic [3:0]         reg_addr;
    logic [31:0]        reg_wdata, reg_rdata, rv;
    logic [15:0]        scaled_out;
    logic signed [17:0] display_level;
    int                 err_count, n_compared, off, sso, ss, s, t1, t2, mx, gain, ext_v;
    logic [31:0]        rst_tab [12] = '{32'h0, 32'h0, 32'h0, 32'h4e20, 32'h0, 32'h1,
                                         32'h64, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

    analog_ramp_generator #(.TICK_CYCLES(T), .NUM_BLOCKS(NB)) analog_ramp_generator_inst (
        .clk(clk), .arst_n(arst_n), .enable(enable), .level_sel(level_sel),
        .decel_stop(decel_stop), .block_values(block_values), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .scaled_out(scaled_out), .display_level(display_level));

    // --------
    // helpers
    // --------
    // expected scaled output
    function automatic logic [31:0] exp_scaled(input int l);
        int q;
        q = (l - off) * 100 / gain;
        if (q > 32767) q = 32767;
        if (q < 0) q = 0;
        return 32'(q);
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("compared %0d, failed %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask

    // bounded wait, then compare
    task automatic wait_lvl(input int x, input int bound);
        int i;
        for (i = 0; i < bound && display_level !== x[17:0]; i++)
            @(posedge clk);
        chk(32'(display_level), 32'(x));
        if (display_level !== x[17:0]) final_report();
    endtask

    // --------
    // clock and sequence
    // --------
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial
    begin
        {arst_n, enable, level_sel, decel_stop, reg_wr, reg_rd} = 6'h0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        err_count = 0;
        n_compared = 0;
        void'($urandom(32'hb63d5f9a));
        block_values = 72'({$urandom, $urandom, $urandom});
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            rd(4'(i), rv);
            chk(rv, rst_tab[i]);
        end
        wr(ramp_pkg::REG_RATE, 32'h0);
        rd(ramp_pkg::REG_RATE, rv);
        chk(rv, 32'h1);
        wr(ramp_pkg::REG_RATE, 32'h3fff);
        rd(ramp_pkg::REG_RATE, rv);
        chk(rv, 32'h2710);
        wr(ramp_pkg::REG_SSO, 32'h7530);
        rd(ramp_pkg::REG_SSO, rv);
        chk(rv, 32'h4e20);
        s = 1 + $urandom % 20;
        off = int'($urandom % 200) - 100;
        sso = $urandom % 100;
        gain = 50 + $urandom % 251;
        ss = off + sso;
        t1 = ss + 5 * s + (s > 1);
        t2 = ss + 2 * s;
        mx = ss + 8 * s + 3;
        wr(ramp_pkg::REG_OFFSET, 32'(off));
        wr(ramp_pkg::REG_SSO, 32'(sso));
        wr(ramp_pkg::REG_RATE, 32'(10 * s));
        wr(ramp_pkg::REG_GAIN, 32'(gain));
        wr(ramp_pkg::REG_MAXLVL, 32'(mx));
        wr(ramp_pkg::REG_TARGET1, 32'(t1));
        wr(ramp_pkg::REG_TARGET2, 32'(t2));
        rd(ramp_pkg::REG_OFFSET, rv);
        chk(rv, 32'(off));
        // start, ramp to target one, settle
        @(posedge clk);
        enable <= 1'b1;
        wait_lvl(ss, 12);
        wait_lvl(t1, 9 * T);
        repeat (2 * T) @(posedge clk);
        wait_lvl(t1, 1);
        chk(32'(scaled_out), exp_scaled(t1));
        rd(ramp_pkg::REG_LEVEL, rv);
        chk(rv, 32'(t1));
        rd(ramp_pkg::REG_STATUS, rv);
        chk(rv, 32'h2);
        // retarget, then cap
        @(posedge clk);
        level_sel <= 1'b1;
        wait_lvl(t2, 7 * T);
        wr(ramp_pkg::REG_TARGET1, 32'(mx + 50));
        level_sel <= 1'b0;
        wait_lvl(mx, 12 * T);
        repeat (2 * T) @(posedge clk);
        wait_lvl(mx, 1);
        // stop, hold, drop, lockout
        @(posedge clk);
        decel_stop <= 1'b1;
        wait_lvl(ss, 14 * T);
        repeat (T / 2) @(posedge clk);
        wait_lvl(ss, 1);
        wait_lvl(off, T + 5);
        repeat (3) @(posedge clk);
        chk(32'(scaled_out), 32'h0);
        rd(ramp_pkg::REG_STATUS, rv);
        chk(rv, 32'h5);
        enable <= 1'b0;
        repeat (10) @(posedge clk);
        enable <= 1'b1;
        repeat (3 * T) @(posedge clk);
        wait_lvl(off, 1);
        decel_stop <= 1'b0;
        repeat (3 * T) @(posedge clk);
        wait_lvl(off, 1);
        enable <= 1'b0;
        repeat (10) @(posedge clk);
        rd(ramp_pkg::REG_STATUS, rv);
        chk(rv, 32'h0);
        enable <= 1'b1;
        wait_lvl(ss, 12);
        // disable in mid-ramp
        repeat (2 * T) @(posedge clk);
        enable <= 1'b0;
        wait_lvl(off, 10);
        repeat (3) @(posedge clk);
        chk(32'(scaled_out), 32'h0);
        // target one from block two
        ext_v = ss + 3 * s;
        block_values[36 +: 18] <= 18'(ext_v);
        wr(ramp_pkg::REG_CTRL, 32'h201);
        enable <= 1'b1;
        wait_lvl(ext_v, 7 * T);
        final_report();
    end
endmodule
`default_nettype wire
